// ===== core/watchdog_pkg.sv
package watchdog_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [1:0] CTRL_OFFSET = 2'h0;
	localparam logic [1:0] STATUS_OFFSET = 2'h1;

	// ----------------------------------------------------------------
	// Control field layout
	// ----------------------------------------------------------------
	localparam int ACTIVATE_BIT = 7;
	localparam int NO_RESET_BIT = 6;
	localparam int TIMEOUT_MSB = 5;
	localparam int TIMEOUT_WIDTH = 6;
	localparam int FLAG_BIT = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h7F;
	localparam logic [5:0] COUNT_RESET = 6'h3F;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int STEP_CYCLES = 12288;
	localparam int RESET_PULSE_CYCLES = 4;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARMED = 2'b01,
		ST_RESET = 2'b10
	} wdg_state_e;

endpackage

// ===== core/step_prescaler.sv
`timescale 1ns/1ps

// Divides the machine clock into one tick per time-out step
module step_prescaler #(
	parameter int STEP = watchdog_pkg::STEP_CYCLES
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic restart_in,
	output logic tick_out
);
	localparam int W = $clog2(STEP);
	localparam logic [W-1:0] LAST = W'(STEP - 1);

	logic [W-1:0] count_q;

	// Prescale counter, restarted on each rewind
	always_ff @(posedge clock_in) begin
		if (!rst_n_in || restart_in) begin
			count_q <= '0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= (count_q == LAST);
			if (count_q == LAST) begin
				count_q <= '0;
			end else begin
				count_q <= count_q + 1'b1;
			end
		end
	end

	AST_TICK_PERIOD: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		tick_out |=> !tick_out)
		else $error("prescaler tick longer than one cycle");

endmodule

// ===== core/software_watchdog_timer.sv
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps

module software_watchdog_timer #(
	parameter int STEP = watchdog_pkg::STEP_CYCLES
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic hw_activate_opt_in,
	input wire logic [1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	output logic mcu_reset_out,
	output logic active_out
);

	// ----------------------------------------------------------------
	// Strap capture
	// ----------------------------------------------------------------
	logic strap_meta_q;
	logic strap_sync_q;
	logic hw_mode_q;
	logic strap_taken_q;

	// Option strap synchroniser, left running through reset
	// A reset here would hand the one-shot capture a zero instead of the strap
	always_ff @(posedge clock_in) begin
		strap_meta_q <= hw_activate_opt_in;
		strap_sync_q <= strap_meta_q;
	end

	// Strap held for the whole run; no register path reaches it
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			hw_mode_q <= 1'b0;
			strap_taken_q <= 1'b0;
		end else if (!strap_taken_q) begin
			hw_mode_q <= strap_sync_q;
			strap_taken_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	logic ctrl_wr;
	logic rewind;
	logic sw_reset_req;
	logic tick;

	// Control write decode
	always_comb begin
		ctrl_wr = wr_in && (addr_in == watchdog_pkg::CTRL_OFFSET);
		sw_reset_req = ctrl_wr && !wdata_in[watchdog_pkg::NO_RESET_BIT];
		// Bit 6 alone reloads, so an idle watchdog still serves as a time base
		rewind = ctrl_wr && wdata_in[watchdog_pkg::NO_RESET_BIT];
	end

	// ----------------------------------------------------------------
	// Activation
	// ----------------------------------------------------------------
	logic sw_active_q;

	// Sticky software activation
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			sw_active_q <= 1'b0;
		end else if (rewind && wdata_in[watchdog_pkg::ACTIVATE_BIT]) begin
			sw_active_q <= 1'b1;
		end
	end

	// Effective activation from software bit or strap
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			active_out <= 1'b0;
		end else begin
			active_out <= sw_active_q || hw_mode_q
				|| (rewind && wdata_in[watchdog_pkg::ACTIVATE_BIT]);
		end
	end

	// ----------------------------------------------------------------
	// Step prescaler and counter
	// ----------------------------------------------------------------
	step_prescaler #(
		.STEP(STEP)
	) u_prescaler (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.restart_in(rewind),
		.tick_out(tick)
	);

	logic [watchdog_pkg::TIMEOUT_WIDTH-1:0] count_q;
	logic expire;

	// Underflow while armed means expiry
	always_comb begin
		expire = tick && (count_q == '0) && active_out;
	end

	// Down counter; six bits bound the time-out to 64 steps
	// While inactive it wraps from zero to the top and keeps going
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			count_q <= watchdog_pkg::COUNT_RESET;
		end else if (rewind) begin
			count_q <= wdata_in[watchdog_pkg::TIMEOUT_MSB:0];
		end else if (tick) begin
			count_q <= count_q - 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Reset generation
	// ----------------------------------------------------------------
	watchdog_pkg::wdg_state_e state_q;
	logic [2:0] pulse_q;
	logic wdg_cause_q;

	// Reset pulse sequencer
	// A request arriving inside a running pulse is absorbed by that pulse
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			state_q <= watchdog_pkg::ST_IDLE;
			pulse_q <= 3'h0;
			mcu_reset_out <= 1'b0;
		end else begin
			case (state_q)
				watchdog_pkg::ST_IDLE: begin
					if (sw_reset_req || expire) begin
						state_q <= watchdog_pkg::ST_RESET;
						mcu_reset_out <= 1'b1;
						pulse_q <= 3'(watchdog_pkg::RESET_PULSE_CYCLES - 1);
					end
				end
				watchdog_pkg::ST_RESET: begin
					if (pulse_q == 3'h0) begin
						state_q <= watchdog_pkg::ST_IDLE;
						mcu_reset_out <= 1'b0;
					end else begin
						pulse_q <= pulse_q - 1'b1;
					end
				end
				default: begin
					state_q <= watchdog_pkg::ST_IDLE;
					mcu_reset_out <= 1'b0;
				end
			endcase
		end
	end

	// Cause flag survives the system reset it triggers, so rst_n_in leaves it alone
	// Expiry in the same cycle as a software request wins
	always_ff @(posedge clock_in) begin
		if (state_q == watchdog_pkg::ST_IDLE && expire) begin
			wdg_cause_q <= 1'b1;
		end else if (state_q == watchdog_pkg::ST_IDLE && sw_reset_req) begin
			wdg_cause_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// Read data one cycle after the strobe
	// Bit 6 reads back as one, the level software must keep there
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			if (addr_in == watchdog_pkg::CTRL_OFFSET) begin
				rdata_out <= {active_out, 1'b1, count_q};
			end else if (addr_in == watchdog_pkg::STATUS_OFFSET) begin
				rdata_out <= {7'h00, wdg_cause_q};
			end else begin
				rdata_out <= 8'h00;
			end
		end else begin
			rdata_out <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Check helpers
	// ----------------------------------------------------------------
	logic [31:0] step_age_q;

	// Cycles into the current step; a rewind or reset restarts a whole step
	always_ff @(posedge clock_in) begin
		if (!rst_n_in || rewind) begin
			step_age_q <= 32'h0000_0000;
		end else if (tick) begin
			step_age_q <= 32'h0000_0001;
		end else begin
			step_age_q <= step_age_q + 32'h0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Activation
	AST_ACTIVE_STICKY: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		$rose(sw_active_q) |=> sw_active_q [*8])
		else $error("software activation dropped");
	AST_ACTIVE_HOLDS: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		active_out |=> active_out)
		else $error("running watchdog stopped");
	AST_START: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(rewind && wdata_in[watchdog_pkg::ACTIVATE_BIT]) |=> active_out)
		else $error("watchdog did not start");
	AST_NO_SELF_START: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(!sw_active_q && !hw_mode_q && !(rewind && wdata_in[watchdog_pkg::ACTIVATE_BIT]))
		|=> !active_out)
		else $error("watchdog started without request");
	AST_HW_MODE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(hw_mode_q && strap_taken_q) |=> active_out)
		else $error("hardware mode not running");
	AST_STRAP_FROZEN: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		strap_taken_q |=> $stable(hw_mode_q))
		else $error("option strap changed during run");

	// Counter
	AST_RELOAD: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		rewind |=> count_q == $past(wdata_in[watchdog_pkg::TIMEOUT_MSB:0]))
		else $error("counter not reloaded");
	AST_REWIND_RESTART: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		rewind |=> !tick)
		else $error("rewind did not restart the step");
	AST_COUNT_DOWN: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(tick && !rewind) |=> count_q == $past(count_q) - 6'h01)
		else $error("counter did not step");
	AST_COUNT_HOLD: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(!tick && !rewind) |=> $stable(count_q))
		else $error("counter moved between steps");
	AST_STEP_LENGTH: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		tick |-> step_age_q == 32'(STEP))
		else $error("step length wrong");

	// Reset generation
	AST_SW_RESET: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(sw_reset_req && state_q == watchdog_pkg::ST_IDLE) |=> mcu_reset_out [*4])
		else $error("software reset pulse wrong");
	AST_PULSE_END: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(state_q == watchdog_pkg::ST_RESET && pulse_q == 3'h0) |=> !mcu_reset_out)
		else $error("reset pulse too long");
	AST_RESET_STATE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(state_q == watchdog_pkg::ST_RESET) |-> mcu_reset_out)
		else $error("reset state without reset output");
	AST_EXPIRE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(expire && state_q == watchdog_pkg::ST_IDLE) |=> mcu_reset_out && wdg_cause_q)
		else $error("expiry gave no reset");
	AST_NO_RESET_IDLE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(!active_out && !sw_reset_req && state_q == watchdog_pkg::ST_IDLE) |=> !mcu_reset_out)
		else $error("reset while inactive");
	AST_CAUSE_CLEAR: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(sw_reset_req && !expire && state_q == watchdog_pkg::ST_IDLE) |=> !wdg_cause_q)
		else $error("cause flag kept after software reset");

	// Read port
	AST_READ: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(rd_in && addr_in == watchdog_pkg::CTRL_OFFSET) |=> rdata_out[5:0] == $past(count_q))
		else $error("read did not return counter");
	AST_READ_TOP: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(rd_in && addr_in == watchdog_pkg::CTRL_OFFSET)
		|=> rdata_out[7:6] == {$past(active_out), 1'b1})
		else $error("control read upper bits wrong");
	AST_READ_STATUS: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(rd_in && addr_in == watchdog_pkg::STATUS_OFFSET)
		|=> rdata_out == {7'h00, $past(wdg_cause_q)})
		else $error("status read wrong");
	AST_UNMAPPED: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(rd_in && addr_in[1]) |=> rdata_out == 8'h00)
		else $error("unmapped read not zero");
	AST_READ_IDLE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		!rd_in |=> rdata_out == 8'h00)
		else $error("read data outside its cycle");

	COV_START: cover property (@(posedge clock_in) rewind && wdata_in[7]);
	COV_EXPIRE: cover property (@(posedge clock_in) expire);
	COV_SW_RESET: cover property (@(posedge clock_in) sw_reset_req);
	COV_STATUS_READ: cover property (@(posedge clock_in) rd_in && addr_in == 2'h1);
	COV_HW_EXPIRE: cover property (@(posedge clock_in) hw_mode_q && expire);

endmodule

// ===== bench/software_watchdog_timer_tb.sv
`timescale 1ns/1ps

// Compare two values, count and report a mismatch
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

module software_watchdog_timer_tb;
	localparam int STEP = 16;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic hw_activate_opt_in = 1'b0;
	logic [1:0] addr_in = 2'h0;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [7:0] rdata_out;
	logic mcu_reset_out;
	logic active_out;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	int pulse_cycles = 0;
	int n;

	software_watchdog_timer #(.STEP(STEP)) dut_u (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.hw_activate_opt_in(hw_activate_opt_in),
		.addr_in(addr_in),
		.wdata_in(wdata_in),
		.wr_in(wr_in),
		.rd_in(rd_in),
		.rdata_out(rdata_out),
		.mcu_reset_out(mcu_reset_out),
		.active_out(active_out)
	);

	// ----------------------------------------------------------------
	// Clock, reset pulse width and run ceiling
	// ----------------------------------------------------------------
	always #12.5 clock_in = ~clock_in;

	always @(posedge clock_in) begin
		cycles++;
		if (mcu_reset_out === 1'b1) pulse_cycles++;
		if (cycles == 5000) begin
			miscompares++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic idle(input int k);
		repeat (k) @(posedge clock_in);
	endtask

	task automatic do_reset(input int k);
		@(posedge clock_in);
		rst_n_in <= 1'b0;
		idle(k);
		rst_n_in <= 1'b1;
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= v;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask

	// Read strobe one cycle, data taken in the following cycle
	task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clock_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1;
		`CHK(rdata_out, exp)
	endtask

	// Bounded wait for the reset request, cycles counted in n
	task automatic wait_reset();
		n = 0;
		while (mcu_reset_out !== 1'b1 && n < 2000) begin
			@(posedge clock_in);
			#1;
			n++;
		end
	endtask

	task automatic print_verdict();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		idle(3);
		rst_n_in <= 1'b1;
		#1;
		`CHK(active_out, 1'b0)
		wr(2'h0, 8'h45);
		idle(8);
		rd_chk(2'h0, 8'h45);
		idle(STEP);
		rd_chk(2'h0, 8'h44);
		wr(2'h0, 8'h40);
		idle(8 + STEP);
		rd_chk(2'h0, 8'h7F);
		`CHK(pulse_cycles, 0)
		$display("test free count done");
		wr(2'h0, 8'hC2);
		#1;
		`CHK(active_out, 1'b1)
		rd_chk(2'h0, 8'hC2);
		wr(2'h0, 8'h42);
		idle(2);
		`CHK(active_out, 1'b1)
		for (int i = 0; i < 4; i++) begin
			idle(STEP);
			wr(2'h0, 8'hC2 + i[7:0]);
		end
		`CHK(pulse_cycles, 0)
		$display("test rewind done");
		wr(2'h0, 8'hC3);
		wait_reset();
		`CHK(n >= 3 * STEP && n <= 4 * STEP + 3, 1'b1)
		idle(6);
		`CHK(pulse_cycles, watchdog_pkg::RESET_PULSE_CYCLES)
		do_reset(3);
		idle(1);
		#1;
		`CHK(active_out, 1'b0)
		rd_chk(2'h1, 8'h01);
		$display("test expiry done");
		wr(2'h0, 8'h00);
		idle(6);
		`CHK(pulse_cycles, 2 * watchdog_pkg::RESET_PULSE_CYCLES)
		rd_chk(2'h1, 8'h00);
		wr(2'h1, 8'hFF);
		rd_chk(2'h1, 8'h00);
		rd_chk(2'h2, 8'h00);
		$display("test software reset done");
		@(posedge clock_in);
		hw_activate_opt_in <= 1'b1;
		do_reset(6);
		idle(4);
		#1;
		`CHK(active_out, 1'b1)
		wr(2'h0, 8'h41);
		wait_reset();
		`CHK(n >= STEP && n <= 2 * STEP + 3, 1'b1)
		$display("test hardware option done");
		print_verdict();
	end
endmodule
